/* design/ccpt_top.sv */
// configuration handshake pins, port lock and test access port
`timescale 1ns/1ps
`include "ccpt_params.svh"
module ccpt_top #(
  parameter int BSC_PINS = 4,                        // boundary pins
  parameter int INIT_LOW_CYC = `CCPT_INIT_LOW_CYC    // init low hold
) (
  input wire logic clk,                         // 200 MHz system clock
  input wire logic sys_rst,                     // async reset, power-up
  input wire logic program_request_n,           // restart request pin
  input wire logic [`CCPT_MODE_W-1:0] mode_pins, // mode select pins
  input wire logic init_ready_n_in,             // init line level
  output logic init_ready_n_out,                // init line value (0)
  output logic init_ready_n_oe,                 // init line pulled low
  input wire logic done_in,                     // done line level
  output logic done_out,                        // done line value (0)
  output logic done_oe,                         // done line pulled low
  input wire logic load_complete,               // data load finished
  input wire logic tck,                         // test clock pin
  input wire logic tms,                         // test mode select pin
  input wire logic tdi,                         // test data in pin
  output logic tdo,                             // test data out
  output logic tdo_oe,                          // test data out enable
  input wire logic [BSC_PINS-1:0] bsc_in,       // pin levels to capture
  output logic [BSC_PINS-1:0] bsc_data,         // update cell data
  output logic [BSC_PINS-1:0] bsc_oe,           // update cell enables
  output ccpt_pkg::ccpt_cfg_e cfg_state,        // configuration phase
  output logic [`CCPT_MODE_W-1:0] cfg_mode,     // latched mode
  output ccpt_pkg::ccpt_port_e port_sel,        // locked port
  output logic port_refused,                    // refused select pulse
  output logic cfg_bit,                         // bit loaded over tap
  output logic cfg_bit_vld                      // pulse with cfg_bit
);
  import ccpt_pkg::*;

  localparam int CNT_W = $clog2(INIT_LOW_CYC + 1);
  localparam int BSC_W = 2 * BSC_PINS;

  // a single-cycle init low would break the restart hold
  if (BSC_PINS < 1 || INIT_LOW_CYC < 2) begin : g_bad_param
    $error("ccpt_top: BSC_PINS below 1 or INIT_LOW_CYC below 2");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int SYN_W = 6 + `CCPT_MODE_W;
  logic [SYN_W-1:0] syn_m_r, syn_s_r;
  logic tck_d_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syn_m_r <= '0;
      syn_s_r <= '0;
      tck_d_r <= 1'b0;
    end else begin
      syn_m_r <= {tck, tms, tdi, program_request_n, init_ready_n_in,
                  done_in, mode_pins};
      syn_s_r <= syn_m_r;
      tck_d_r <= syn_s_r[SYN_W-1];
    end
  end

  wire tck_s = syn_s_r[SYN_W-1];
  wire tms_s = syn_s_r[SYN_W-2];
  wire tdi_s = syn_s_r[SYN_W-3];
  wire prog_s = syn_s_r[SYN_W-4];
  wire init_s = syn_s_r[SYN_W-5];
  wire [`CCPT_MODE_W-1:0] mode_s = syn_s_r[`CCPT_MODE_W-1:0];
  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;

  // ****************************************************************
  // configuration sequence
  // ****************************************************************
  ccpt_cfg_e cfg_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic init_d_r;
  logic od_zero_r;
  wire init_rise = init_s & ~init_d_r;
  wire cnt_end = (cnt_r == CNT_W'(INIT_LOW_CYC - 1));

  always_comb begin
    case (cfg_state)
      CCPT_CLEAR: cfg_nxt = (cnt_end && prog_s) ? CCPT_WAIT_INIT
                                                : CCPT_CLEAR;
      CCPT_WAIT_INIT: cfg_nxt = init_rise ? CCPT_LOAD : CCPT_WAIT_INIT;
      CCPT_LOAD: cfg_nxt = load_complete ? CCPT_DONE : CCPT_LOAD;
      CCPT_DONE: cfg_nxt = CCPT_DONE;
      default: cfg_nxt = CCPT_CLEAR;
    endcase
    if (!prog_s) begin
      cfg_nxt = CCPT_CLEAR;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_state <= CCPT_CLEAR;
      cnt_r <= '0;
      init_d_r <= 1'b0;
      od_zero_r <= 1'b0;
    end else begin
      cfg_state <= cfg_nxt;
      init_d_r <= init_s;
      od_zero_r <= 1'b0;
      if (cfg_state != CCPT_CLEAR || !prog_s) begin
        cnt_r <= '0;
      end else if (!cnt_end) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  // open-drain: value is always low, only the enable moves
  assign init_ready_n_out = od_zero_r;
  assign done_out = od_zero_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_ready_n_oe <= 1'b1;
      done_oe <= 1'b1;
      cfg_mode <= `CCPT_MODE_RST;
    end else begin
      init_ready_n_oe <= (cfg_nxt == CCPT_CLEAR);
      done_oe <= (cfg_nxt != CCPT_DONE);
      if (cfg_state == CCPT_WAIT_INIT && init_rise) begin
        cfg_mode <= mode_s;
      end
    end
  end

  // ****************************************************************
  // test access port
  // ****************************************************************
  ccpt_tap_e tap_st;
  ccpt_tap u_tap (
    .clk(clk),
    .sys_rst(sys_rst),
    .tck_rise(tck_rise),
    .tms(tms_s),
    .state_r(tap_st)
  );

  function automatic logic dr_is_bsc(input logic [`CCPT_IR_W-1:0] ir);
    dr_is_bsc = (ir == `CCPT_IR_EXTEST) || (ir == `CCPT_IR_SAMPLE);
  endfunction : dr_is_bsc

  logic [`CCPT_IR_W-1:0] ir_r, ir_sh_r;
  logic [BSC_W-1:0] bsc_sh_r;
  logic byp_r;
  wire use_bsc = dr_is_bsc(ir_r);
  wire dr_out = use_bsc ? bsc_sh_r[0] : byp_r;
  wire shifting = (tap_st == CCPT_SH_DR) || (tap_st == CCPT_SH_IR);
  wire tdo_nxt = (tap_st == CCPT_SH_IR) ? ir_sh_r[0] : dr_out;
  wire cfg_shift = tck_rise && tap_st == CCPT_SH_DR &&
                   ir_r == `CCPT_IR_CFG_LOAD && port_sel == CCPT_PORT_TAP &&
                   cfg_state == CCPT_LOAD;

  // capture and shift on the rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_sh_r <= `CCPT_IR_CAPTURE;
      bsc_sh_r <= '0;
      byp_r <= 1'b0;
    end else if (tck_rise) begin
      case (tap_st)
        CCPT_CAP_IR: ir_sh_r <= `CCPT_IR_CAPTURE;
        CCPT_SH_IR: ir_sh_r <= {tdi_s, ir_sh_r[`CCPT_IR_W-1:1]};
        CCPT_CAP_DR: begin
          byp_r <= 1'b0;
          if (use_bsc) begin
            bsc_sh_r <= {bsc_oe, bsc_in};
          end
        end
        CCPT_SH_DR: begin
          byp_r <= tdi_s;
          if (use_bsc) begin
            bsc_sh_r <= {tdi_s, bsc_sh_r[BSC_W-1:1]};
          end
        end
        default: byp_r <= byp_r;
      endcase
    end
  end

  // outputs and updates on the fall, as the port expects
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_r <= `CCPT_IR_BYPASS;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      bsc_data <= '0;
      bsc_oe <= '0;
    end else if (tck_fall) begin
      tdo <= tdo_nxt;
      tdo_oe <= shifting;
      if (tap_st == CCPT_TLR) begin
        ir_r <= `CCPT_IR_BYPASS;
      end else if (tap_st == CCPT_UPD_IR) begin
        ir_r <= ir_sh_r;
      end
      if (tap_st == CCPT_UPD_DR && use_bsc) begin
        bsc_data <= bsc_sh_r[BSC_PINS-1:0];
        bsc_oe <= bsc_sh_r[BSC_W-1:BSC_PINS];
      end
    end
  end

  // ****************************************************************
  // port selection and lock
  // ****************************************************************
  // lock only clears on power-up reset; program request does not free it
  wire tap_sel_req = tck_fall && tap_st == CCPT_UPD_IR &&
                     ir_sh_r == `CCPT_IR_CFG_EN;
  wire pin_sel_req = cfg_state == CCPT_WAIT_INIT && init_rise;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_sel <= CCPT_PORT_NONE;
      port_refused <= 1'b0;
      cfg_bit <= 1'b0;
      cfg_bit_vld <= 1'b0;
    end else begin
      port_refused <= tap_sel_req && port_sel == CCPT_PORT_PINS;
      if (port_sel == CCPT_PORT_NONE) begin
        if (tap_sel_req) begin
          port_sel <= CCPT_PORT_TAP;
        end else if (pin_sel_req) begin
          port_sel <= CCPT_PORT_PINS;
        end
      end
      cfg_bit_vld <= cfg_shift;
      if (cfg_shift) begin
        cfg_bit <= tdi_s;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_mode_capture: assert property (
    @(posedge clk) disable iff (sys_rst)
    (cfg_state == CCPT_WAIT_INIT && init_rise) |=> cfg_mode == $past(mode_s))
    else $error("mode not latched at init rise");

  a_prog_restart: assert property (
    @(posedge clk) disable iff (sys_rst)
    !prog_s |=> cfg_state == CCPT_CLEAR ##1 init_ready_n_oe)
    else $error("program request did not restart configuration");

  a_init_open_drain: assert property (
    @(posedge clk) disable iff (sys_rst)
    (cfg_state == CCPT_CLEAR && !cnt_end) |-> init_ready_n_oe &&
    !init_ready_n_out)
    else $error("init line not pulled low while clearing");

  a_done_release: assert property (
    @(posedge clk) disable iff (sys_rst)
    (cfg_state == CCPT_LOAD && load_complete && prog_s) |=>
    cfg_state == CCPT_DONE && !done_oe)
    else $error("done line not released on completion");

  a_tap_cfg_only: assert property (
    @(posedge clk) disable iff (sys_rst)
    cfg_bit_vld |-> port_sel == CCPT_PORT_TAP)
    else $error("data taken over test port without its selection");

  a_port_locked: assert property (
    @(posedge clk) disable iff (sys_rst)
    port_sel != CCPT_PORT_NONE |=> $stable(port_sel))
    else $error("locked configuration port changed");

  a_tdo_on_fall: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($changed(tdo) || $changed(tdo_oe)) |-> $past(tck_fall))
    else $error("test data output moved off a falling edge");

  a_bsc_on_fall: assert property (
    @(posedge clk) disable iff (sys_rst)
    ($changed(bsc_data) || $changed(bsc_oe)) |-> $past(tck_fall))
    else $error("boundary outputs moved off a falling edge");

endmodule : ccpt_top

/* common/ccpt_params.svh */
// constants for the configuration pin and test port block
// What this block does
// - latch the three mode pins when the init-ready line rises
// - program request held low restarts the configuration sequence
// - init-ready line is open drain, pulled low or released only
// - open-drain done line is released once configuration is complete
// - test port becomes configuration port after its enable command
// - first selected configuration port stays locked until power-up
// - test data output and its enable change on test clock fall
// - boundary update cells change outputs on test clock fall
`ifndef CCPT_PARAMS_SVH
`define CCPT_PARAMS_SVH

`define CCPT_CLK_PERIOD_NS 5
`define CCPT_INIT_LOW_NS 1000
`define CCPT_INIT_LOW_CYC \
  ((`CCPT_INIT_LOW_NS + `CCPT_CLK_PERIOD_NS - 1) / `CCPT_CLK_PERIOD_NS)

`define CCPT_MODE_W 3
`define CCPT_MODE_RST 3'h0
`define CCPT_IR_W 4
`define CCPT_IR_EXTEST 4'h0
`define CCPT_IR_SAMPLE 4'h1
`define CCPT_IR_CFG_EN 4'h6
`define CCPT_IR_CFG_LOAD 4'h7
`define CCPT_IR_BYPASS 4'hF
`define CCPT_IR_CAPTURE 4'h1

`endif

/* common/ccpt_pkg.sv */
// types shared by the configuration pin and test port block
package ccpt_pkg;

  typedef enum logic [3:0] {
    CCPT_TLR = 4'h0, CCPT_RTI = 4'h1, CCPT_SEL_DR = 4'h3,
    CCPT_CAP_DR = 4'h2, CCPT_SH_DR = 4'h6, CCPT_EX1_DR = 4'h7,
    CCPT_PAU_DR = 4'h5, CCPT_EX2_DR = 4'h4, CCPT_UPD_DR = 4'hC,
    CCPT_SEL_IR = 4'hD, CCPT_CAP_IR = 4'hF, CCPT_SH_IR = 4'hE,
    CCPT_EX1_IR = 4'hA, CCPT_PAU_IR = 4'hB, CCPT_EX2_IR = 4'h9,
    CCPT_UPD_IR = 4'h8
  } ccpt_tap_e;

  typedef enum logic [1:0] {
    CCPT_CLEAR = 2'h0, CCPT_WAIT_INIT = 2'h1,
    CCPT_LOAD = 2'h3, CCPT_DONE = 2'h2
  } ccpt_cfg_e;

  typedef enum logic [1:0] {
    CCPT_PORT_NONE = 2'h0, CCPT_PORT_PINS = 2'h1, CCPT_PORT_TAP = 2'h2
  } ccpt_port_e;

endpackage : ccpt_pkg

/* design/ccpt_tap.sv */
// test port state machine, advanced on sampled test clock rises
`timescale 1ns/1ps
module ccpt_tap (
  input wire logic clk,               // system clock
  input wire logic sys_rst,           // async reset, active high
  input wire logic tck_rise,          // one-cycle test clock rise
  input wire logic tms,               // synchronised mode select
  output ccpt_pkg::ccpt_tap_e state_r // present state
);
  import ccpt_pkg::*;

  ccpt_tap_e state_nxt;

  always_comb begin
    case (state_r)
      CCPT_TLR: state_nxt = tms ? CCPT_TLR : CCPT_RTI;
      CCPT_RTI: state_nxt = tms ? CCPT_SEL_DR : CCPT_RTI;
      CCPT_SEL_DR: state_nxt = tms ? CCPT_SEL_IR : CCPT_CAP_DR;
      CCPT_CAP_DR: state_nxt = tms ? CCPT_EX1_DR : CCPT_SH_DR;
      CCPT_SH_DR: state_nxt = tms ? CCPT_EX1_DR : CCPT_SH_DR;
      CCPT_EX1_DR: state_nxt = tms ? CCPT_UPD_DR : CCPT_PAU_DR;
      CCPT_PAU_DR: state_nxt = tms ? CCPT_EX2_DR : CCPT_PAU_DR;
      CCPT_EX2_DR: state_nxt = tms ? CCPT_UPD_DR : CCPT_SH_DR;
      CCPT_UPD_DR: state_nxt = tms ? CCPT_SEL_DR : CCPT_RTI;
      CCPT_SEL_IR: state_nxt = tms ? CCPT_TLR : CCPT_CAP_IR;
      CCPT_CAP_IR: state_nxt = tms ? CCPT_EX1_IR : CCPT_SH_IR;
      CCPT_SH_IR: state_nxt = tms ? CCPT_EX1_IR : CCPT_SH_IR;
      CCPT_EX1_IR: state_nxt = tms ? CCPT_UPD_IR : CCPT_PAU_IR;
      CCPT_PAU_IR: state_nxt = tms ? CCPT_EX2_IR : CCPT_PAU_IR;
      CCPT_EX2_IR: state_nxt = tms ? CCPT_UPD_IR : CCPT_SH_IR;
      CCPT_UPD_IR: state_nxt = tms ? CCPT_SEL_DR : CCPT_RTI;
      default: state_nxt = CCPT_TLR;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= CCPT_TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  a_tap_moves_rise: assert property (
    @(posedge clk) disable iff (sys_rst)
    !tck_rise |=> $stable(state_r))
    else $error("test port state moved without a test clock rise");

endmodule : ccpt_tap

/* sim/ccpt_jtag_host.sv */
// test controller model driving the test port pins
`timescale 1ns/1ps
module ccpt_jtag_host (
  input wire logic clk, // system clock
  input wire logic tdo, // test data out
  output logic tck,     // test clock, still between frames
  output logic tms,     // mode select, starts high, left low after each scan
  output logic tdi      // data in, pulled up
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one test clock period of 32 clk, 16 a phase; tdo taken before the rise
  task step(input logic m, input logic d, output logic q);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (15) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (16) @(posedge clk);
    tck <= 1'b0;
  endtask : step

  task reset_tap;
    logic q;
    repeat (6) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : reset_tap

  // run-test/idle to shift, n bits lsb first, back to run-test/idle
  task scan(input logic ir, input int n, input logic [7:0] din,
            output logic [7:0] dout);
    logic q;
    dout = 8'h00;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    tdi <= 1'b1;
  endtask : scan
endmodule : ccpt_jtag_host

/* sim/testbench.sv */
// self-checking bench for the configuration pins and test port
`timescale 1ns/1ps
`include "ccpt_params.svh"
module testbench;
  import ccpt_pkg::*;
  localparam int NB = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic program_request_n = 1'b1;
  logic [`CCPT_MODE_W-1:0] mode_pins = 3'h0;
  logic host_init_low = 1'b0;
  logic load_complete = 1'b0;
  logic [NB-1:0] bsc_in = 4'h0;
  logic init_line, done_line, init_o, init_oe, done_o, done_oe;
  logic tck, tms, tdi, tdo, tdo_oe, port_refused, cfg_bit, cfg_bit_vld;
  logic [NB-1:0] bsc_data, bsc_oe;
  logic [`CCPT_MODE_W-1:0] cfg_mode, m;
  ccpt_cfg_e cfg_state;
  ccpt_port_e port_sel;
  logic [7:0] q, d, bits_seen;
  int n_errors = 0, checks = 0, cyc = 0, n_ref = 0, n_bits = 0, n_early = 0;
  int n_oe = 0, n_oe0 = 0;

  // open-drain lines with pull-ups
  assign init_line = !((init_oe && !init_o) || host_init_low);
  assign done_line = !(done_oe && !done_o);
  always #2.5 clk = ~clk;

  ccpt_top #(.BSC_PINS(NB), .INIT_LOW_CYC(4)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .program_request_n(program_request_n),
    .mode_pins(mode_pins), .init_ready_n_in(init_line),
    .init_ready_n_out(init_o), .init_ready_n_oe(init_oe),
    .done_in(done_line), .done_out(done_o), .done_oe(done_oe),
    .load_complete(load_complete), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .bsc_in(bsc_in), .bsc_data(bsc_data),
    .bsc_oe(bsc_oe), .cfg_state(cfg_state), .cfg_mode(cfg_mode),
    .port_sel(port_sel), .port_refused(port_refused),
    .cfg_bit(cfg_bit), .cfg_bit_vld(cfg_bit_vld));
  // undriven test output shows the inverse of its last value
  ccpt_jtag_host jh (.clk(clk), .tdo(tdo_oe ? tdo : !tdo), .tck(tck),
    .tms(tms), .tdi(tdi));

  // ***********************
  // watchers
  // ***********************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (port_refused === 1'b1) n_ref <= n_ref + 1;
    if ($rose(tck) && tdo_oe === 1'b1) n_oe <= n_oe + 1;
    if (cfg_bit_vld === 1'b1) begin
      bits_seen[n_bits[2:0]] <= cfg_bit;
      n_bits <= n_bits + 1;
    end
    // test outputs may only move while the test clock is low
    if (!sys_rst && tck && $changed({tdo, tdo_oe, bsc_data, bsc_oe}))
      n_early <= n_early + 1;
  end

  // ***********************
  // helpers
  // ***********************
  function automatic logic [7:0] bypass_out(input logic [7:0] x);
    return {x[6:0], 1'b0};
  endfunction : bypass_out

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wait_st(input ccpt_cfg_e st);
    for (int k = 0; k < 400 && cfg_state !== st; k++) @(posedge clk);
    #1;
    chk("cfg_state", st, cfg_state);
  endtask : wait_st

  task summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    wait (cyc == 20000);
    n_errors++;
    summarize();
  end

  // ***********************
  // main sequence
  // ***********************
  initial begin
    q = $urandom(32'h3f59);
    repeat (12) @(posedge clk);
    #1;
    chk("init_oe", 1, init_oe);
    chk("done_oe", 1, done_oe);
    chk("port_sel", CCPT_PORT_NONE, port_sel);
    chk("tdo_oe", 0, tdo_oe);
    @(posedge clk);
    sys_rst <= 1'b0;
    host_init_low <= 1'b1;
    mode_pins <= $urandom;
    wait_st(CCPT_WAIT_INIT);
    chk("init_oe", 0, init_oe);
    m = $urandom;
    @(posedge clk);
    mode_pins <= m;
    repeat (10) @(posedge clk);
    host_init_low <= 1'b0;
    wait_st(CCPT_LOAD);
    chk("cfg_mode", m, cfg_mode);
    chk("port_sel", CCPT_PORT_PINS, port_sel);
    @(posedge clk);
    mode_pins <= ~m;
    load_complete <= 1'b1;
    @(posedge clk);
    load_complete <= 1'b0;
    wait_st(CCPT_DONE);
    repeat (3) @(posedge clk);
    #1;
    chk("done_oe", 0, done_oe);
    chk("done_o", 0, done_o);
    chk("cfg_mode", m, cfg_mode);
    chk("init_o", 0, init_o);
    $display("test pin configuration finished");
    jh.reset_tap();
    jh.scan(1'b1, 4, 8'h06, q);
    repeat (5) @(posedge clk);
    #1;
    chk("ir capture", 8'h01, q);
    chk("refused", 1, n_ref);
    chk("port_sel", CCPT_PORT_PINS, port_sel);
    @(posedge clk);
    program_request_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("init_oe", 1, init_oe);
    chk("cfg_state", CCPT_CLEAR, cfg_state);
    @(posedge clk);
    program_request_n <= 1'b1;
    wait_st(CCPT_LOAD);
    chk("port_sel", CCPT_PORT_PINS, port_sel);
    $display("test refuse and restart finished");
    @(posedge clk);
    sys_rst <= 1'b1;
    host_init_low <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    jh.reset_tap();
    jh.scan(1'b1, 4, 8'h06, q);
    repeat (5) @(posedge clk);
    #1;
    chk("port_sel", CCPT_PORT_TAP, port_sel);
    @(posedge clk);
    host_init_low <= 1'b0;
    wait_st(CCPT_LOAD);
    chk("port_sel", CCPT_PORT_TAP, port_sel);
    jh.scan(1'b1, 4, 8'h07, q);
    d = $urandom;
    jh.scan(1'b0, 8, d, q);
    repeat (5) @(posedge clk);
    #1;
    chk("bit count", 8, n_bits);
    chk("bits", d, bits_seen);
    $display("test port configuration finished");
    jh.scan(1'b1, 4, 8'h00, q);
    d = $urandom;
    m = $urandom;
    bsc_in <= {1'b0, m};
    jh.scan(1'b0, 8, d, q);
    repeat (5) @(posedge clk);
    #1;
    chk("bsc_data", d[3:0], bsc_data);
    chk("bsc_oe", d[7:4], bsc_oe);
    chk("bsc capture", {1'b0, m}, q[3:0]);
    jh.scan(1'b1, 4, 8'h0F, q);
    d = $urandom;
    n_oe0 = n_oe;
    jh.scan(1'b0, 8, d, q);
    chk("bypass", bypass_out(d), q);
    chk("tdo_oe shifts", 8, n_oe - n_oe0);
    chk("early change", 0, n_early);
    $display("test boundary and bypass finished");
    summarize();
  end
endmodule : testbench
